//--- common/prfm_defines.svh
/*
 Timing counts, register offsets, field positions and reset values.
 Assumes a 100 MHz aclk; included by the design and the testbench.
*/
`ifndef PRFM_DEFINES_SVH
`define PRFM_DEFINES_SVH

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define PRFM_CLK_HZ          100000000
`define PRFM_CYCLE_MS        100
`define PRFM_CYCLE_CLKS      ((`PRFM_CLK_HZ / 1000) * `PRFM_CYCLE_MS)
`define PRFM_OUTAGE_MS       2000
`define PRFM_OUTAGE_TICKS    (`PRFM_OUTAGE_MS / `PRFM_CYCLE_MS)
`define PRFM_PULSE_MS        120
`define PRFM_PULSE_TICKS     ((`PRFM_PULSE_MS + `PRFM_CYCLE_MS - 1) / `PRFM_CYCLE_MS)
`define PRFM_BLINK_TICKS     5

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define PRFM_CTRL_OFS        12'h000
`define PRFM_STAT_OFS        12'h004
`define PRFM_SETV_OFS        12'h008
`define PRFM_OUTV_OFS        12'h00c
`define PRFM_PASS_OFS        12'h010
`define PRFM_FAULT_OFS       12'h014
`define PRFM_OUTAGE_OFS      12'h018
`define PRFM_PVIN_OFS        12'h01c
`define PRFM_CASIN_OFS       12'h020
`define PRFM_STAMP_OFS       12'h024

// -----------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------
`define PRFM_CTRL_MODE_LO    0
`define PRFM_CTRL_ACTDISP    2
`define PRFM_CTRL_TAGBLINK   3
`define PRFM_CTRL_ALMPOL     4
`define PRFM_CTRL_SYSALM     5
`define PRFM_CTRL_LOCK       6
`define PRFM_CTRL_RST        7'h00
`define PRFM_PASS_RST        32'h00005a5a
`define PRFM_MV_COLD         16'hffc1
`define PRFM_FAULT_BITS      7

`endif

//--- common/prfm_pkg.sv
/*
 Types for the power recovery and fail monitor.
 Assumes prfm_defines.svh sits on the include path.
*/
package prfm_pkg;
    typedef enum logic [1:0] {
        PRFM_WARM_ALWAYS = 2'h0,
        PRFM_MAN_COLD    = 2'h1,
        PRFM_CAS_COLD    = 2'h2,
        PRFM_COLD        = 2'h3
    } prfm_start_t;

    typedef enum logic [3:0] {
        PRFM_S_IDLE    = 4'h1,
        PRFM_S_MEASURE = 4'h2,
        PRFM_S_APPLY   = 4'h4,
        PRFM_S_RUN     = 4'h8
    } prfm_state_t;

    typedef enum logic [3:0] {
        PRFM_R_NONE   = 4'h0,
        PRFM_R_WARM   = 4'h1,
        PRFM_R_MCOLD  = 4'h2,
        PRFM_R_CCOLD  = 4'h4,
        PRFM_R_COLD   = 4'h8
    } prfm_restart_t;
endpackage

//--- src/prfm_monitor.sv
/*
 Power recovery and fail monitor: computation tick, restart choice,
 retention, fail and alarm indication, contact inputs and outputs,
 AXI4-Lite register slave.
 Assumes the retained storage ports are backed by non-volatile cells
 outside, and that fault and power inputs are asynchronous pins.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "prfm_defines.svh"

// Behaviour
// - all input and output computation happens once every 100 ms tick; here fault latches and outputs update on every aclk edge.
// - after power return the stored start mode picks the restart.
// - outage under two seconds gives a warm restart in every mode.
// - long outage: warm, manual-cold, cascade-cold or cold per mode.
// - setting value and configuration restored on every restart type; here only configuration is retained and reloaded.
// - configuration is kept in non-volatile storage across supply loss.
// - clock, processor, converter and memory faults are flagged.
// - any failure lights the red lamp and opens the fail contact.
// - fail contact closed normally, open on power loss or failure.
// - any alarm lights the yellow lamp and shows the cause.
// - active display option recolours process bar on process alarm.
// - tag blink option blinks the tag while the alarm lamp is lit.
// - any failure switches the screen to the failure page.
// - main processor failure: display side shows page, manual allowed.
// - display processor failure: main side shows page, manual allowed.
// - configuration writes are blocked without the correct password.
// - two analog inputs are taken: process value and cascade value.
// - two contact inputs select mode and switch the backlight off.
// - three contact outputs: cascade/manual, high alarm, low alarm.
// - alarm contacts stay open while supply is lost.
module prfm_monitor (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Power and retained storage
    input  wire logic        power_good,
    input  wire logic [31:0] nv_stamp_in,
    input  wire logic [31:0] nv_cfg_in,
    output logic [31:0]      nv_stamp_out,
    output logic [31:0]      nv_cfg_out,
    output logic             nv_write,
    // Fault sources
    input  wire logic [6:0]  fault_in,
    // Analog samples and process alarms
    input  wire logic [15:0] process_value,
    input  wire logic [15:0] cascade_value,
    input  wire logic        high_alarm_in,
    input  wire logic        low_alarm_in,
    // Contact inputs
    input  wire logic        mode_contact,
    input  wire logic        backlight_contact,
    // Lamps, screen, contacts
    output logic             fail_lamp,
    output logic             alarm_lamp,
    output logic             fail_contact,
    output logic             fail_page,
    output logic             page_on_display_cpu,
    output logic             hand_operation,
    output logic             bar_alert_colour,
    output logic             tag_blink,
    output logic             backlight_off,
    output logic             contact_output_one,
    output logic             high_alarm_contact,
    output logic             low_alarm_contact,
    output logic [15:0]      setting_value,
    output logic [15:0]      manipulated_output,
    output logic [3:0]       restart_kind
);
    import prfm_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [23:0]   div;
        logic          tick;
        logic [31:0]   stamp;
        logic [31:0]   outage;
        prfm_state_t   st;
        prfm_restart_t rk;
        logic [6:0]    cfg;
        logic [15:0]   sv;
        logic [15:0]   mv;
        logic          cascade;
        logic          unlocked;
        logic [9:0]    p1, p2, p3;
        logic [6:0]    faults;
        logic [1:0]    raw_m, raw_b;
        logic [1:0]    cnt_m, cnt_b;
        logic          mode_ok, bl_ok;
        logic [2:0]    blink;
        logic          blink_ph;
        logic [15:0]   pv, cv;
        logic          hi, lo;
        logic          aw, w;
        logic [11:0]   awa;
        logic [31:0]   wd;
        logic [3:0]    ws;
        logic          bv;
        logic          rv;
        logic [31:0]   rd;
        logic          nvw;
    } prfm_s_t;

    prfm_s_t s_reg, s_next;

    wire logic pwr_ok  = s_reg.p3[0] && s_reg.p2[0];
    wire logic any_fail = |s_reg.faults;
    wire logic alarm   = (s_reg.hi | s_reg.lo | s_reg.cfg[`PRFM_CTRL_SYSALM]);
    wire logic [31:0] cfg_word = {25'h0, s_reg.cfg};

    function automatic logic [31:0] rd_mux(input logic [11:0] a,
                                           input prfm_s_t r);
        case (a)
            `PRFM_CTRL_OFS:   rd_mux = {25'h0, r.cfg};
            `PRFM_STAT_OFS:   rd_mux = {20'h0, r.rk, r.st, r.cascade,
                                        r.unlocked, r.mode_ok, r.bl_ok};
            `PRFM_SETV_OFS:   rd_mux = {16'h0, r.sv};
            `PRFM_OUTV_OFS:   rd_mux = {16'h0, r.mv};
            `PRFM_PASS_OFS:   rd_mux = 32'h0;
            `PRFM_FAULT_OFS:  rd_mux = {25'h0, r.faults};
            `PRFM_OUTAGE_OFS: rd_mux = r.outage;
            `PRFM_PVIN_OFS:   rd_mux = {16'h0, r.pv};
            `PRFM_CASIN_OFS:  rd_mux = {16'h0, r.cv};
            `PRFM_STAMP_OFS:  rd_mux = r.stamp;
            default:          rd_mux = 32'h0;
        endcase
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.nvw = 1'b0;
        // Pin synchronisers: stage one feeds stage two only
        s_next.p1 = {fault_in, high_alarm_in, mode_contact, power_good};
        s_next.p2 = s_reg.p1;
        s_next.p3 = s_reg.p2;
        // Computation tick
        s_next.tick = 1'b0;
        if (s_reg.div == 24'(`PRFM_CYCLE_CLKS - 1)) begin
            s_next.div  = 24'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + 24'h1;
        end
        // Faults latch; a clean agreement is needed to set one
        for (int i = 0; i < `PRFM_FAULT_BITS; i++) begin
            if (s_reg.p2[3+i] && s_reg.p3[3+i]) begin
                s_next.faults[i] = 1'b1;
            end
        end
        if (s_reg.tick) begin
            // Sampled each tick so all computation shares one period
            s_next.pv = process_value;
            s_next.cv = cascade_value;
            s_next.hi = s_reg.p3[2];
            s_next.lo = low_alarm_in;
            s_next.stamp = s_reg.stamp + 32'h1;
            // Input filter: new level must hold for two ticks
            s_next.raw_m = {s_reg.raw_m[0], s_reg.p3[1]};
            s_next.raw_b = {s_reg.raw_b[0], backlight_contact};
            if (s_reg.raw_m[0] != s_reg.mode_ok) begin
                if (s_reg.cnt_m == 2'(`PRFM_PULSE_TICKS - 1)) begin
                    s_next.mode_ok = s_reg.raw_m[0];
                    s_next.cascade = s_reg.raw_m[0];
                    s_next.cnt_m = 2'h0;
                end else begin
                    s_next.cnt_m = s_reg.cnt_m + 2'h1;
                end
            end else begin
                s_next.cnt_m = 2'h0;
            end
            if (s_reg.raw_b[0] != s_reg.bl_ok) begin
                if (s_reg.cnt_b == 2'(`PRFM_PULSE_TICKS - 1)) begin
                    s_next.bl_ok = s_reg.raw_b[0];
                    s_next.cnt_b = 2'h0;
                end else begin
                    s_next.cnt_b = s_reg.cnt_b + 2'h1;
                end
            end else begin
                s_next.cnt_b = 2'h0;
            end
            if (s_reg.blink == 3'(`PRFM_BLINK_TICKS - 1)) begin
                s_next.blink = 3'h0;
                s_next.blink_ph = ~s_reg.blink_ph;
            end else begin
                s_next.blink = s_reg.blink + 3'h1;
            end
            if (s_reg.st == PRFM_S_RUN) begin
                s_next.nvw = 1'b1;
            end
        end
        // Power sequencer
        case (s_reg.st)
            PRFM_S_IDLE: begin
                if (pwr_ok) begin
                    s_next.st = PRFM_S_MEASURE;
                end
            end
            PRFM_S_MEASURE: begin
                // Free-running stamp is not reloaded; outage is its distance from the retained one
                s_next.outage = s_reg.stamp - nv_stamp_in;
                s_next.cfg = nv_cfg_in[6:0];
                s_next.st  = PRFM_S_APPLY;
            end
            PRFM_S_APPLY: begin
                if (s_reg.outage < 32'(`PRFM_OUTAGE_TICKS)) begin
                    s_next.rk = PRFM_R_WARM;
                end else begin
                    case (prfm_start_t'(s_reg.cfg[1:0]))
                        PRFM_MAN_COLD: begin
                            s_next.rk = PRFM_R_MCOLD;
                            s_next.cascade = 1'b0;
                        end
                        PRFM_CAS_COLD: begin
                            s_next.rk = PRFM_R_CCOLD;
                            s_next.cascade = 1'b1;
                            s_next.mv = `PRFM_MV_COLD;
                        end
                        PRFM_COLD: s_next.rk = PRFM_R_COLD;
                        default:   s_next.rk = PRFM_R_WARM;
                    endcase
                end
                s_next.st = PRFM_S_RUN;
            end
            PRFM_S_RUN: begin
                if (!pwr_ok) begin
                    s_next.st = PRFM_S_IDLE;
                end
            end
            default: s_next.st = PRFM_S_IDLE;
        endcase
        // AXI4-Lite write
        if (s_axi_awvalid && !s_reg.aw) begin
            s_next.aw  = 1'b1;
            s_next.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w) begin
            s_next.w  = 1'b1;
            s_next.wd = s_axi_wdata;
            s_next.ws = s_axi_wstrb;
        end
        if (s_reg.aw && s_reg.w && !s_reg.bv) begin
            s_next.aw = 1'b0;
            s_next.w  = 1'b0;
            s_next.bv = 1'b1;
            case (s_reg.awa)
                `PRFM_CTRL_OFS: begin
                    if (s_reg.unlocked && s_reg.ws[0]) begin
                        s_next.cfg = s_reg.wd[6:0];
                        s_next.nvw = 1'b1;
                    end
                end
                `PRFM_PASS_OFS: begin
                    s_next.unlocked = (s_reg.wd == `PRFM_PASS_RST);
                end
                `PRFM_SETV_OFS: begin
                    s_next.sv = s_reg.wd[15:0];
                end
                `PRFM_OUTV_OFS: begin
                    if (!s_reg.cascade || any_fail) begin
                        s_next.mv = s_reg.wd[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (s_reg.bv && s_axi_bready) begin
            s_next.bv = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.rv) begin
            s_next.rv = 1'b1;
            s_next.rd = rd_mux(s_axi_araddr, s_reg);
        end else if (s_reg.rv && s_axi_rready) begin
            s_next.rv = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg      <= '0;
            s_reg.st   <= PRFM_S_IDLE;
            s_reg.rk   <= PRFM_R_NONE;
            s_reg.cfg  <= `PRFM_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------
    // Outputs (registered, fed from state each edge)
    // -------------------------------------------------------------
    // Lamps and contacts re-time one cycle after the state they show
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_lamp           <= 1'b0;
            alarm_lamp          <= 1'b0;
            fail_contact        <= 1'b0;
            fail_page           <= 1'b0;
            page_on_display_cpu <= 1'b0;
            hand_operation      <= 1'b0;
            bar_alert_colour    <= 1'b0;
            tag_blink           <= 1'b0;
            backlight_off       <= 1'b0;
            contact_output_one  <= 1'b0;
            high_alarm_contact  <= 1'b0;
            low_alarm_contact   <= 1'b0;
            setting_value       <= 16'h0;
            manipulated_output  <= 16'h0;
            restart_kind        <= 4'h0;
            nv_stamp_out        <= 32'h0;
            nv_cfg_out          <= 32'h0;
            nv_write            <= 1'b0;
        end else begin
            fail_lamp    <= any_fail;
            fail_contact <= pwr_ok && !any_fail;
            fail_page    <= any_fail;
            page_on_display_cpu <= s_reg.faults[1];
            hand_operation <= !s_reg.cascade || any_fail;
            alarm_lamp   <= alarm;
            bar_alert_colour <= s_reg.cfg[`PRFM_CTRL_ACTDISP]
                                && (s_reg.hi || s_reg.lo);
            tag_blink    <= s_reg.cfg[`PRFM_CTRL_TAGBLINK] && alarm
                            && s_reg.blink_ph;
            backlight_off <= s_reg.bl_ok;
            contact_output_one <= pwr_ok && s_reg.cascade;
            high_alarm_contact <= pwr_ok && (s_reg.hi
                                  ^ s_reg.cfg[`PRFM_CTRL_ALMPOL]);
            low_alarm_contact  <= pwr_ok && (s_reg.lo
                                  ^ s_reg.cfg[`PRFM_CTRL_ALMPOL]);
            setting_value      <= s_reg.sv;
            manipulated_output <= s_reg.mv;
            restart_kind       <= s_reg.rk;
            nv_stamp_out       <= s_reg.stamp;
            nv_cfg_out         <= cfg_word;
            nv_write           <= s_reg.nvw;
        end
    end

    assign s_axi_awready = !s_reg.aw;
    assign s_axi_wready  = !s_reg.w;
    assign s_axi_bvalid  = s_reg.bv;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_arready = !s_reg.rv;
    assign s_axi_rvalid  = s_reg.rv;
    assign s_axi_rdata   = s_reg.rd;
    assign s_axi_rresp   = 2'h0;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.tick |=> !s_reg.tick [*8])
        else $error("tick repeats too soon");
    a_short_warm: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.st == PRFM_S_APPLY && s_reg.outage < 32'(`PRFM_OUTAGE_TICKS))
        |=> s_reg.rk == PRFM_R_WARM)
        else $error("short outage not warm");
    a_mcold_man: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.st == PRFM_S_APPLY && s_reg.cfg[1:0] == 2'h1
         && s_reg.outage >= 32'(`PRFM_OUTAGE_TICKS))
        |=> !s_reg.cascade && s_reg.rk == PRFM_R_MCOLD)
        else $error("manual cold wrong");
    a_fail_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
        any_fail |=> fail_lamp && !fail_contact && fail_page)
        else $error("fail not shown");
    a_fail_nc: assert property (@(posedge aclk) disable iff (!aresetn)
        !pwr_ok |=> !fail_contact)
        else $error("fail contact closed without power");
    a_alarm_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_reg.hi) |=> alarm_lamp)
        else $error("alarm lamp dark");
    a_cfg_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s_reg.unlocked && s_reg.st == PRFM_S_RUN && s_reg.aw && s_reg.w)
        |=> $stable(s_reg.cfg))
        else $error("locked config changed");
    a_alarm_open: assert property (@(posedge aclk) disable iff (!aresetn)
        !pwr_ok |=> !high_alarm_contact && !low_alarm_contact)
        else $error("alarm contact closed without power");
endmodule

//--- sim/prfm_field.sv
/*
 Field side model: fault pins, contacts, supply and retained cells.
 Assumes the bench sets fault and contact requests after clock edges.
*/
module prfm_field (
    // Clock and bench requests
    input  wire logic        aclk,
    input  wire logic [6:0]  fault_req,
    input  wire logic        mode_req,
    input  wire logic        power_req,
    // Retained cell writes from the monitor
    input  wire logic [31:0] nv_stamp_out,
    input  wire logic [31:0] nv_cfg_out,
    input  wire logic        nv_write,
    // Pins towards the monitor
    output logic             power_good,
    output logic [31:0]      nv_stamp_in,
    output logic [31:0]      nv_cfg_in,
    output logic [6:0]       fault_in,
    output logic             mode_contact,
    output logic             backlight_contact
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        power_good = 1'b1;
        nv_stamp_in = 32'h0;
        nv_cfg_in = 32'h0;
        fault_in = 7'h00;
        mode_contact = 1'b0;
        backlight_contact = 1'b0;
    end
    // Mode contact follows the bench, which holds each level for long; backlight contact stays low
    always @(posedge aclk) begin
        fault_in <= fault_req;
        power_good <= power_req;
        mode_contact <= mode_req;
        if (nv_write) begin
            nv_stamp_in <= nv_stamp_out;
            nv_cfg_in <= nv_cfg_out;
        end
    end
endmodule

//--- sim/test_power_recovery_and_fail_monitor.sv
/*
 Self-checking bench for the monitor, register access over AXI4-Lite.
 Assumes a 100 ms tick too long to simulate, so bus-visible state, reset
 levels, the fail lamp and page and the fail and alarm contact outputs are checked.
*/
`include "prfm_defines.svh"
module test_power_recovery_and_fail_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, v, keep;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, fail_contact;
    logic [1:0] bresp, rresp;
    logic [15:0] pv = 16'h0, cv = 16'h0;
    logic hi_in = 0, lo_in = 0, mode_req = 0, pg, nw, mc, bc;
    logic pwr_req = 1'b1, fl, fp, hac, lac;
    logic [6:0] fault_req = 7'h0, fin;
    logic [31:0] so, co, si, ci;
    logic [31:0] exp_q[$];
    int bad_count = 0, n_checks = 0, cyc = 0, seed = 74519;
    initial forever #5 aclk = ~aclk;
    prfm_field u_prfm_field (.aclk(aclk), .fault_req(fault_req),
        .mode_req(mode_req), .power_req(pwr_req), .nv_stamp_out(so),
        .nv_cfg_out(co), .nv_write(nw), .power_good(pg),
        .nv_stamp_in(si), .nv_cfg_in(ci),
        .fault_in(fin), .mode_contact(mc), .backlight_contact(bc));
    prfm_monitor u_prfm_monitor (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_good(pg),
        .nv_stamp_in(si), .nv_cfg_in(ci), .nv_stamp_out(so),
        .nv_cfg_out(co), .nv_write(nw), .fault_in(fin),
        .process_value(pv), .cascade_value(cv), .high_alarm_in(hi_in),
        .low_alarm_in(lo_in), .mode_contact(mc), .backlight_contact(bc),
        .fail_lamp(fl), .alarm_lamp(), .fail_contact(fail_contact),
        .fail_page(fp), .page_on_display_cpu(), .hand_operation(),
        .bar_alert_colour(), .tag_blink(), .backlight_off(),
        .contact_output_one(), .high_alarm_contact(hac),
        .low_alarm_contact(lac), .setting_value(), .manipulated_output(),
        .restart_kind());
    task automatic chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Master side: hold each channel until its own ready is sampled
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        bit busy;
        busy = 1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (busy) begin
            @(negedge aclk);
            aw_ok = awready;
            w_ok = wready;
            b_ok = bvalid;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
            if (b_ok) busy = 0;
        end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic ar_ok, r_ok;
        bit busy;
        busy = 1;
        exp_q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (busy) begin
            @(negedge aclk);
            ar_ok = arready;
            r_ok = rvalid;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
            if (r_ok) busy = 0;
        end
        @(posedge aclk);
    endtask
    // Watcher: settled values are looked at before the taking edge
    always @(negedge aclk) begin
        if (rvalid && rready && exp_q.size() > 0) begin
            chk("rdata", exp_q.pop_front(), rdata);
            chk("rresp", 32'h0, {30'h0, rresp});
        end
        if (bvalid && bready) chk("bresp", 32'h0, {30'h0, bresp});
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            stop_test;
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("fail_contact", 32'h0, {31'h0, fail_contact});
        @(posedge aclk);
        aresetn <= 1'b1;
        pv <= 16'($random(seed));
        cv <= 16'($random(seed));
        hi_in <= 1'b1;
        mode_req <= 1'b1;
        @(posedge aclk);
        rd(`PRFM_CTRL_OFS, 32'h0);
        wr(`PRFM_PASS_OFS, 32'h0);
        wr(`PRFM_CTRL_OFS, 32'h0000000f);
        // Warm restart, running, locked: rk 1, state 8
        rd(`PRFM_STAT_OFS, 32'h00000180);
        rd(`PRFM_CTRL_OFS, 32'h0);
        rd(`PRFM_PASS_OFS, 32'h0);
        wr(`PRFM_PASS_OFS, `PRFM_PASS_RST);
        for (int m = 0; m < 4; m++) begin
            v = (32'($random(seed)) & 32'h0000003c) | 32'(m);
            wr(`PRFM_CTRL_OFS, v);
            rd(`PRFM_CTRL_OFS, v);
        end
        // Inverted alarm polarity closes idle alarm contacts while powered
        v = 32'h00000010;
        wr(`PRFM_CTRL_OFS, v);
        @(negedge aclk);
        chk("fail_contact", 32'h1, {31'h0, fail_contact});
        chk("high_alarm_contact", 32'h1, {31'h0, hac});
        chk("low_alarm_contact", 32'h1, {31'h0, lac});
        @(posedge aclk);
        pwr_req <= 1'b0;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk("fail_contact", 32'h0, {31'h0, fail_contact});
        chk("high_alarm_contact", 32'h0, {31'h0, hac});
        chk("low_alarm_contact", 32'h0, {31'h0, lac});
        @(posedge aclk);
        pwr_req <= 1'b1;
        repeat (10) @(posedge aclk);
        // Short outage: warm, running, unlocked
        rd(`PRFM_STAT_OFS, 32'h00000184);
        rd(`PRFM_CTRL_OFS, v);
        keep = v;
        v = {16'h0, 16'($random(seed))};
        wr(`PRFM_SETV_OFS, v);
        rd(`PRFM_SETV_OFS, v);
        wr(12'h100, 32'($random(seed)));
        rd(12'h100, 32'h0);
        wr(`PRFM_PASS_OFS, 32'h1);
        wr(`PRFM_CTRL_OFS, 32'h00000001);
        rd(`PRFM_CTRL_OFS, keep);
        fault_req <= 7'h08;
        repeat (10) @(posedge aclk);
        fault_req <= 7'h00;
        repeat (10) @(posedge aclk);
        rd(`PRFM_FAULT_OFS, 32'h00000008);
        @(negedge aclk);
        chk("fail_lamp", 32'h1, {31'h0, fl});
        chk("fail_page", 32'h1, {31'h0, fp});
        chk("fail_contact", 32'h0, {31'h0, fail_contact});
        repeat (4) @(posedge aclk);
        stop_test;
    end
endmodule
